// ==== rtl/ptc_cfg.svh ====
// Constants of the pulse time counter
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH
`define PTC_CNT_W        16
`define PTC_CNT_ZERO     16'h0000
`define PTC_CNT_ONE      16'h0001
`define PTC_PRE_W        4
`define PTC_DIV_W        16
`define PTC_FILT_W       15
`define PTC_NUM_CLK      4
`define PTC_NUM_PIN      4
`define PTC_CLK_PERIOD_NS 25
`endif

// ==== rtl/ptc_pkg.sv ====
// Types of the pulse time counter
package ptc_pkg;
    typedef enum logic {
        PTC_CLOCK_COUNT_MODE = 1'b0,
        PTC_EDGE_COUNT_MODE  = 1'b1
    } ptc_mode_t;
    typedef enum logic [1:0] {
        PTC_ST_IDLE  = 2'b00,
        PTC_ST_RUN   = 2'b01,
        PTC_ST_MATCH = 2'b11
    } ptc_state_t;
endpackage : ptc_pkg

// ==== rtl/ptc_tick_if.sv ====
// Tick carrier between the source stage and the counter
`timescale 1ns/1ps
interface ptc_tick_if;
    logic tick;
    logic active;
    modport src (output tick, output active);
    modport dst (input tick, input active);
endinterface : ptc_tick_if

// ==== rtl/ptc_source.sv ====
// Source selection, prescaler and glitch filter
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_source
    import ptc_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    input  wire logic                       enable,
    input  wire ptc_mode_t                  mode,
    input  wire logic [1:0]                 pulse_input_select,
    input  wire logic                       pulse_input_polarity,
    input  wire logic                       divider_bypass,
    input  wire logic [1:0]                 divider_clock_select,
    input  wire logic [`PTC_PRE_W-1:0]      prescale_value,
    input  wire logic [`PTC_NUM_CLK-1:0]    clock_sources,
    input  wire logic [`PTC_NUM_PIN-1:0]    pulse_inputs,
    ptc_tick_if.src                         tk
);
    logic                    clk_src;
    logic                    pin_lvl;
    logic                    src_lvl;
    logic                    src_d_reg;
    logic                    src_rise;
    logic [`PTC_DIV_W-1:0]   div_reg;
    logic [`PTC_DIV_W-1:0]   div_next;
    logic                    div_tick;
    logic [`PTC_FILT_W-1:0]  filt_reg;
    logic                    filt_lvl_reg;
    logic                    filt_d_reg;
    logic [`PTC_FILT_W:0]    filt_len;

    assign clk_src  = clock_sources[divider_clock_select];
    assign pin_lvl  = pulse_inputs[pulse_input_select] ^ pulse_input_polarity;
    assign src_lvl  = (mode == PTC_EDGE_COUNT_MODE) ? pin_lvl : clk_src;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            src_d_reg <= 1'b0;
        end else begin
            src_d_reg <= src_lvl;
        end
    end
    assign src_rise = src_lvl & ~src_d_reg;

    // Divider counts source rising edges; bit n toggles every 2^n edges
    assign div_next = div_reg + `PTC_DIV_W'(1);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_reg <= '0;
        end else if (!enable) begin
            div_reg <= '0;
        end else if (src_rise) begin
            div_reg <= div_next;
        end
    end
    // Bit n rising is one tick per 2^(n+1) edges
    assign div_tick = src_rise & ~div_reg[prescale_value] & div_next[prescale_value];

    // Filter: level must hold 2^n clocks; n=0 treated as 1 (unsupported)
    assign filt_len = (prescale_value == '0) ? (`PTC_FILT_W+1)'(2)
                    : ((`PTC_FILT_W+1)'(1) << prescale_value);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            filt_reg     <= '0;
            filt_lvl_reg <= 1'b0;
        end else if (!enable || pin_lvl == filt_lvl_reg) begin
            filt_reg <= '0;
        end else if ({1'b0, filt_reg} == filt_len - (`PTC_FILT_W+1)'(1)) begin
            filt_reg     <= '0;
            filt_lvl_reg <= pin_lvl;
        end else begin
            filt_reg <= filt_reg + `PTC_FILT_W'(1);
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            filt_d_reg <= 1'b0;
        end else begin
            filt_d_reg <= filt_lvl_reg;
        end
    end

    always_comb begin
        if (divider_bypass) begin
            tk.tick = src_rise;
        end else if (mode == PTC_EDGE_COUNT_MODE) begin
            tk.tick = filt_lvl_reg & ~filt_d_reg;
        end else begin
            tk.tick = div_tick;
        end
    end
    assign tk.active = enable;
endmodule : ptc_source

// ==== rtl/ptc_counter.sv ====
// Counter core with compare, flag and event outputs
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_counter
    import ptc_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic                   free_run_select,
    input  wire logic [`PTC_CNT_W-1:0]  compare_value,
    input  wire logic                   flag_clear,
    ptc_tick_if.dst                     tk,
    output logic [`PTC_CNT_W-1:0]       counter_value,
    output logic                        compare_flag,
    output logic                        match_evt
);
    logic [`PTC_CNT_W-1:0] cnt_reg;
    logic                  flag_reg;

    assign match_evt = tk.active & tk.tick & (cnt_reg == compare_value);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= `PTC_CNT_ZERO;
        end else if (!tk.active) begin
            cnt_reg <= `PTC_CNT_ZERO;
        end else if (match_evt && !free_run_select) begin
            cnt_reg <= `PTC_CNT_ZERO;
        end else if (tk.tick) begin
            cnt_reg <= cnt_reg + `PTC_CNT_ONE;
        end
    end

    // New match wins over a clear in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_reg <= 1'b0;
        end else if (!tk.active) begin
            flag_reg <= 1'b0;
        end else if (match_evt) begin
            flag_reg <= 1'b1;
        end else if (flag_clear) begin
            flag_reg <= 1'b0;
        end
    end

    assign counter_value = cnt_reg;
    assign compare_flag  = flag_reg;

    a_disable_clears: assert property (@(posedge clk) disable iff (!arst_n)
        !tk.active |=> (cnt_reg == `PTC_CNT_ZERO) && !flag_reg)
        else $error("counter or flag not cleared while disabled");
    a_match_sets_flag: assert property (@(posedge clk) disable iff (!arst_n)
        match_evt |=> flag_reg)
        else $error("flag not set after match");
    a_wrap_to_zero: assert property (@(posedge clk) disable iff (!arst_n)
        match_evt && !free_run_select |=> cnt_reg == `PTC_CNT_ZERO)
        else $error("counter did not return to zero on match");
    a_free_run_inc: assert property (@(posedge clk) disable iff (!arst_n)
        tk.active && tk.tick && free_run_select
        |=> cnt_reg == $past(cnt_reg) + `PTC_CNT_ONE)
        else $error("free run counter did not advance");
    a_count_hold: assert property (@(posedge clk) disable iff (!arst_n)
        tk.active && !tk.tick |=> $stable(cnt_reg))
        else $error("counter moved without a tick");
    a_clear_flag: assert property (@(posedge clk) disable iff (!arst_n)
        flag_clear && !match_evt |=> !flag_reg)
        else $error("flag not cleared by software");
    a_flag_holds: assert property (@(posedge clk) disable iff (!arst_n)
        flag_reg && tk.active && !flag_clear |=> flag_reg)
        else $error("flag dropped on its own");
    // A tick in the start cycle would legally move the count
    a_range_ok: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(tk.active) && !tk.tick ##1 (tk.active && !free_run_select && !tk.tick)[*2]
        |-> cnt_reg == `PTC_CNT_ZERO)
        else $error("counter not zero after start");
    a_range_bound: assert property (@(posedge clk) disable iff (!arst_n)
        tk.active && !free_run_select && cnt_reg <= compare_value
        |=> cnt_reg <= $past(compare_value))
        else $error("counter beyond compare period");

    c_match: cover property (@(posedge clk) disable iff (!arst_n) match_evt);
    c_clear_race: cover property (@(posedge clk) disable iff (!arst_n) match_evt && flag_clear);
    c_free_wrap: cover property (@(posedge clk) disable iff (!arst_n)
        free_run_select && tk.tick && cnt_reg == 16'hFFFF);
endmodule : ptc_counter

// ==== rtl/ptc_top.sv ====
// Pulse time counter top level
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_top
    import ptc_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    input  wire logic                       enable,
    input  wire ptc_mode_t                  mode,
    input  wire logic                       free_run_select,
    input  wire logic                       divider_bypass,
    input  wire logic [1:0]                 divider_clock_select,
    input  wire logic [`PTC_PRE_W-1:0]      prescale_value,
    input  wire logic [1:0]                 pulse_input_select,
    input  wire logic                       pulse_input_polarity,
    input  wire logic [`PTC_CNT_W-1:0]      compare_value,
    input  wire logic                       compare_irq_enable,
    input  wire logic                       dma_enable,
    input  wire logic                       flag_clear,
    input  wire logic [`PTC_NUM_CLK-1:0]    clock_sources,
    input  wire logic [`PTC_NUM_PIN-1:0]    pulse_inputs,
    output logic [`PTC_CNT_W-1:0]           counter_value,
    output logic                            compare_match_status,
    output logic                            trigger_out,
    output logic                            irq,
    output logic                            dma_req
);
    ptc_tick_if tk ();
    logic match_evt;
    logic trig_reg;
    logic dma_reg;

    ptc_source u_src (
        .clk                  (clk),
        .arst_n               (arst_n),
        .enable               (enable),
        .mode                 (mode),
        .pulse_input_select   (pulse_input_select),
        .pulse_input_polarity (pulse_input_polarity),
        .divider_bypass       (divider_bypass),
        .divider_clock_select (divider_clock_select),
        .prescale_value       (prescale_value),
        .clock_sources        (clock_sources),
        .pulse_inputs         (pulse_inputs),
        .tk                   (tk)
    );

    ptc_counter u_cnt (
        .clk             (clk),
        .arst_n          (arst_n),
        .free_run_select (free_run_select),
        .compare_value   (compare_value),
        .flag_clear      (flag_clear),
        .tk              (tk),
        .counter_value   (counter_value),
        .compare_flag    (compare_match_status),
        .match_evt       (match_evt)
    );

    // Registered so trigger and request line up with the flag
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_reg <= 1'b0;
        end else begin
            trig_reg <= match_evt;
        end
    end

    // Request held until the flag clears, like a level DMA request
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dma_reg <= 1'b0;
        end else if (!enable || !dma_enable) begin
            dma_reg <= 1'b0;
        end else if (match_evt) begin
            dma_reg <= 1'b1;
        end else if (flag_clear) begin
            dma_reg <= 1'b0;
        end
    end

    assign trigger_out = trig_reg;
    assign dma_req     = dma_reg;
    assign irq         = compare_match_status & compare_irq_enable;

    // Ticks are edges, so two matches never fall on adjacent cycles
    a_trig_pulse: assert property (@(posedge clk) disable iff (!arst_n)
        trigger_out |=> !trigger_out)
        else $error("trigger longer than one cycle");
    a_match_trig: assert property (@(posedge clk) disable iff (!arst_n)
        match_evt |=> trigger_out && compare_match_status)
        else $error("no trigger or flag after match");
    a_trig_flag: assert property (@(posedge clk) disable iff (!arst_n)
        trigger_out |-> compare_match_status)
        else $error("trigger without flag");
    a_dma_gated: assert property (@(posedge clk) disable iff (!arst_n)
        !dma_enable |=> !dma_req)
        else $error("dma request while disabled");
    a_irq_drop: assert property (@(posedge clk) disable iff (!arst_n)
        flag_clear && !match_evt && compare_irq_enable ##1 compare_irq_enable |-> !irq)
        else $error("irq stayed after clear");

    c_trig: cover property (@(posedge clk) disable iff (!arst_n) trigger_out && irq);
    c_dma: cover property (@(posedge clk) disable iff (!arst_n) dma_req);
endmodule : ptc_top

// ==== tb/ptc_ext_model.sv ====
// Behavioural model of the external pulse pins and chip clock sources
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_ext_model (
    input  wire logic                  clk,
    output logic [`PTC_NUM_CLK-1:0]    clock_sources,
    output logic [`PTC_NUM_PIN-1:0]    pulse_inputs
);
    logic [7:0] lvl_reg;
    assign {clock_sources, pulse_inputs} = lvl_reg;
    initial lvl_reg = 8'h00;
    // Bit k: 0-3 pulse pins, 4-7 clock sources; each level holds h clocks
    task automatic pulses(input int k, input int n, input int h);
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge clk);
            #1 lvl_reg[k] = ~lvl_reg[k];
            repeat (h - 1) @(posedge clk);
        end
    endtask : pulses
    task automatic idle(input logic [3:0] pins);
        lvl_reg = {4'h0, pins};
    endtask : idle
endmodule : ptc_ext_model

// ==== tb/ptc_top_tb_top.sv ====
// Self-checking bench of the pulse time counter
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_top_tb_top
    import ptc_pkg::*;
;
    logic clk, arst_n, enable, free_run_select, divider_bypass, pulse_input_polarity;
    logic compare_irq_enable, dma_enable, flag_clear, compare_match_status;
    logic trigger_out, irq, dma_req;
    ptc_mode_t mode;
    logic [1:0] divider_clock_select, pulse_input_select;
    logic [`PTC_PRE_W-1:0] prescale_value;
    logic [`PTC_CNT_W-1:0] compare_value, counter_value;
    logic [`PTC_NUM_CLK-1:0] clock_sources;
    logic [`PTC_NUM_PIN-1:0] pulse_inputs;
    int miscompares, compares, cycles, trig_cnt;

    ptc_top DUT (.clk(clk), .arst_n(arst_n), .enable(enable), .mode(mode),
        .free_run_select(free_run_select), .divider_bypass(divider_bypass),
        .divider_clock_select(divider_clock_select), .prescale_value(prescale_value),
        .pulse_input_select(pulse_input_select), .pulse_input_polarity(pulse_input_polarity),
        .compare_value(compare_value), .compare_irq_enable(compare_irq_enable),
        .dma_enable(dma_enable), .flag_clear(flag_clear), .clock_sources(clock_sources),
        .pulse_inputs(pulse_inputs), .counter_value(counter_value),
        .compare_match_status(compare_match_status), .trigger_out(trigger_out),
        .irq(irq), .dma_req(dma_req));
    ptc_ext_model ext (.clk(clk), .clock_sources(clock_sources), .pulse_inputs(pulse_inputs));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // One-cycle trigger pulses are counted here so no check can miss one
    always @(posedge clk) begin
        cycles++;
        if (trigger_out === 1'b1) trig_cnt++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : w
    task automatic cfg(input ptc_mode_t m, input logic fr, input logic byp,
                       input logic [3:0] pre, input logic [1:0] sel, input logic pol,
                       input logic [15:0] cmp);
        w(1);
        enable = 1'b0;
        ext.idle({4{pol}});
        mode = m;
        {free_run_select, divider_bypass, prescale_value} = {fr, byp, pre};
        {pulse_input_select, divider_clock_select, pulse_input_polarity} = {sel, sel, pol};
        compare_value = cmp;
        w(3);
        enable = 1'b1;
        trig_cnt = 0;
        w(1);
    endtask : cfg

    task automatic t_match();
        cfg(PTC_CLOCK_COUNT_MODE, 1'b0, 1'b1, 4'h0, 2'h2, 1'b0, 16'h0001);
        ext.pulses(6, 1, 2);
        w(3);
        chk(counter_value, 16'h0001);
        chk({15'h0, compare_match_status}, 16'h0000);
        ext.pulses(6, 1, 2);
        w(3);
        chk(counter_value, 16'h0000);
        chk({13'h0, compare_match_status, irq, dma_req}, 16'h0007);
        chk(trig_cnt[15:0], 16'h0001);
        w(6);
        chk({15'h0, compare_match_status}, 16'h0001);
        compare_irq_enable = 1'b0;
        w(1);
        chk({15'h0, irq}, 16'h0000);
        compare_irq_enable = 1'b1;
        flag_clear = 1'b1;
        w(1);
        flag_clear = 1'b0;
        w(1);
        chk({13'h0, compare_match_status, irq, dma_req}, 16'h0000);
        dma_enable = 1'b0;
        ext.pulses(6, 2, 2);
        w(3);
        chk({13'h0, compare_match_status, irq, dma_req}, 16'h0006);
        dma_enable = 1'b1;
    endtask : t_match

    task automatic t_disable_freerun();
        cfg(PTC_CLOCK_COUNT_MODE, 1'b1, 1'b1, 4'h0, 2'h1, 1'b0, 16'h0001);
        ext.pulses(5, 3, 2);
        w(3);
        chk(counter_value, 16'h0003);
        chk({15'h0, compare_match_status}, 16'h0001);
        enable = 1'b0;
        w(2);
        chk({counter_value[14:0], compare_match_status}, 16'h0000);
        ext.pulses(5, 2, 2);
        w(3);
        chk(counter_value, 16'h0000);
    endtask : t_disable_freerun

    task automatic t_pins();
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                cfg(PTC_EDGE_COUNT_MODE, 1'b0, 1'b1, 4'h0, s[1:0], p[0], 16'h00FF);
                ext.pulses((s + 1) % 4, 1, 2);
                ext.pulses(4 + s, 1, 2);
                w(3);
                chk(counter_value, 16'h0000);
                ext.pulses(s, 2, 2);
                w(3);
                chk(counter_value, 16'h0002);
                // Only an inverted pin counts a move to the low level
                ext.idle({4{~p[0]}});
                w(3);
                chk(counter_value, 16'h0003);
            end
        end
    endtask : t_pins

    task automatic t_divide_filter();
        cfg(PTC_CLOCK_COUNT_MODE, 1'b0, 1'b0, 4'h0, 2'h0, 1'b0, 16'h00FF);
        ext.pulses(4, 8, 2);
        w(3);
        chk(counter_value, 16'h0004);
        cfg(PTC_CLOCK_COUNT_MODE, 1'b0, 1'b0, 4'h1, 2'h3, 1'b0, 16'h00FF);
        ext.pulses(7, 8, 2);
        w(3);
        chk(counter_value, 16'h0002);
        cfg(PTC_EDGE_COUNT_MODE, 1'b0, 1'b0, 4'h2, 2'h1, 1'b0, 16'h00FF);
        ext.pulses(1, 1, 1);
        w(12);
        chk(counter_value, 16'h0000);
        ext.pulses(1, 2, 10);
        w(12);
        chk(counter_value, 16'h0002);
        ext.pulses(1, 1, 3);
        w(12);
        chk(counter_value, 16'h0002);
        ext.pulses(1, 1, 4);
        w(12);
        chk(counter_value, 16'h0003);
    endtask : t_divide_filter

    task automatic finish_test();
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        {miscompares, compares, cycles, trig_cnt} = '0;
        {arst_n, enable, free_run_select, divider_bypass, pulse_input_polarity} = '0;
        {compare_irq_enable, dma_enable, flag_clear} = 3'b110;
        mode = PTC_CLOCK_COUNT_MODE;
        {divider_clock_select, pulse_input_select, prescale_value} = '0;
        compare_value = 16'h0001;
        repeat (16) @(posedge clk);
        #1 arst_n = 1'b1;
        chk({counter_value[11:0], compare_match_status, irq, dma_req, trigger_out}, 16'h0000);
        t_match();
        t_disable_freerun();
        t_pins();
        t_divide_filter();
        finish_test();
    end
endmodule : ptc_top_tb_top
